// ==== scdc_pkg.sv ====
package scdc_pkg;
  // Register byte addresses
  localparam int ADDR_W = 6;
  localparam logic [5:0] A_MODE = 6'h00;
  localparam logic [5:0] A_CMD = 6'h04;
  localparam logic [5:0] A_RX_BASE = 6'h08;
  localparam logic [5:0] A_TX_BASE = 6'h0c;
  localparam logic [5:0] A_FCR = 6'h10;
  localparam logic [5:0] A_MAX_RX_LEN = 6'h14;
  localparam logic [5:0] A_RX_PTR = 6'h18;
  localparam logic [5:0] A_TX_PTR = 6'h1c;
  localparam logic [5:0] A_RX_CNT = 6'h20;
  localparam logic [5:0] A_TX_CNT = 6'h24;
  localparam logic [5:0] A_STATUS = 6'h28;
  // Mode register fields
  localparam int MODE_TX_EN = 0;
  localparam int MODE_RX_EN = 1;
  // Command codes, written to bits 3:0 of the command register
  localparam logic [3:0] CMD_HALT_TX = 4'h1;
  localparam logic [3:0] CMD_GRACEFUL_HALT = 4'h2;
  localparam logic [3:0] CMD_RESTART_TX = 4'h3;
  localparam logic [3:0] CMD_INIT_TX = 4'h4;
  localparam logic [3:0] CMD_INIT_RX = 4'h5;
  localparam logic [3:0] CMD_INIT_BOTH = 4'h6;
  localparam logic [3:0] CMD_CLOSE_RX = 4'h7;
  // Reset values and descriptor geometry
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [15:0] FCR_RST = 16'h1818;
  localparam logic [15:0] DESC_STEP = 16'h0008;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {TX_OFF, TX_IDLE, TX_SEND, TX_HALT} scdc_tx_t;
  typedef enum logic [1:0] {RX_OFF, RX_IDLE, RX_FILL} scdc_rx_t;

  // Next descriptor: wrap bit sends the ring back to its base
  function automatic logic [15:0] scdc_adv(input logic [15:0] p, input logic [15:0] b, input logic w);
    return w ? b : p + DESC_STEP;
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] scdc_merge(input logic [15:0] o, input logic [31:0] d, input logic [3:0] s);
    return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction
endpackage

// ==== scdc_ctr.sv ====
`timescale 1ns/100ps
module scdc_ctr import scdc_pkg::*; #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic clr,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic dec,
  // Count
  output logic [W-1:0] cnt
);
  logic [W-1:0] next_cnt;

  // Down count stops at zero so a buffer is never overrun
  always_comb begin
    next_cnt = cnt;
    if (clr) begin
      next_cnt = '0;
    end else if (load) begin
      next_cnt = load_val;
    end else if (dec && cnt != '0) begin
      next_cnt = cnt - W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule // scdc_ctr

// ==== scdc_axil.sv ====
`timescale 1ns/100ps
module scdc_axil import scdc_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_full, w_full;
  logic next_aw_full, next_w_full, next_awready, next_wready, next_bvalid;
  logic next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [31:0] next_wr_data, next_rdata;
  logic [3:0] next_wr_strb;

  // Write fires once address and data are both held, in either order
  assign wr_en = aw_full && w_full && !bvalid;
  assign rd_addr = araddr;

  always_comb begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (awvalid && awready) begin
      next_aw_full = 1'b1;
      next_wr_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_full = 1'b1;
      next_wr_data = wdata;
      next_wr_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_en) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_err ? RESP_SLVERR : RESP_OK;
    end
    // Ready is registered; held low while a response waits
    next_awready = !next_aw_full && !next_bvalid;
    next_wready = !next_w_full && !next_bvalid;
  end

  // Read answers at the edge after the address handshake
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata = rd_data;
      next_rresp = rd_err ? RESP_SLVERR : RESP_OK;
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OK;
      wr_addr <= '0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OK;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end
endmodule // scdc_axil

// ==== scdc_top.sv ====
// Notes on behaviour
// - Never store more bytes into a receive buffer than the maximum length.
// - Transmit byte count comes from the descriptor length, not the receive limit.
// - New maximum receive length takes effect only at the next receive descriptor.
// - Receive pointer marks next or current descriptor; reloads from base at reset, ring end.
// - Transmit pointer marks next or current descriptor; reloads from base at reset, ring end.
// - Transmit counter loads descriptor length and counts down per byte read.
// - Receive counter loads maximum length and counts down per byte written.
// - Close command closes the partly filled receive buffer for software.
// - Clearing transmit enable disables the transmitter and holds it in reset.
// - On re-enable, transmit starts at the pointed descriptor once it is ready; if still halted at re-enable, it waits in TX_HALT for CMD_RESTART_TX.
// - Clearing receive enable aborts reception at once and holds receiver in reset.
// - On enable, reception starts at the pointed descriptor if it is empty.
// - Transmit reinitialise command, while disabled, restores transmit reset state.
// - Receive reinitialise command, while disabled, restores receive reset state.
// - Combined reinitialise resets both directions of this channel only; the code resets each direction only while that direction is disabled.
`timescale 1ns/100ps
module scdc_top import scdc_pkg::*; #(
  parameter int LEN_W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register port
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transmit descriptor and DMA side
  input wire logic tx_desc_ready,
  input wire logic [LEN_W-1:0] tx_desc_len,
  input wire logic tx_desc_wrap,
  input wire logic tx_byte_rd,
  output logic [15:0] tx_descriptor_pointer,
  output logic tx_rd_ok,
  output logic tx_desc_done,
  output logic [7:0] tx_function_code,
  // Receive descriptor and DMA side
  input wire logic rx_desc_empty,
  input wire logic rx_desc_wrap,
  input wire logic rx_byte_wr,
  input wire logic rx_frame_end,
  output logic [15:0] rx_descriptor_pointer,
  output logic rx_wr_ok,
  output logic rx_desc_close,
  output logic [7:0] rx_function_code
);
  logic wr_en, wr_err, rd_err;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  logic [15:0] channel_mode_register, rx_descriptor_base, tx_descriptor_base;
  logic [15:0] fcr, max_rx_buffer_length;
  logic [15:0] next_mode, next_rx_base, next_tx_base, next_fcr, next_max_len;
  logic [15:0] next_tx_ptr, next_rx_ptr;
  scdc_tx_t tx_st, next_tx_st;
  scdc_rx_t rx_st, next_rx_st;
  logic tx_halted, tx_grace, tx_wrap, tx_fresh;
  logic next_tx_halted, next_tx_grace, next_tx_wrap, next_tx_fresh, next_tx_done, next_tx_rd_ok;
  logic rx_open, rx_wrap, rx_fresh;
  logic next_rx_open, next_rx_wrap, next_rx_fresh, next_rx_close, next_rx_wr_ok;
  logic [LEN_W-1:0] tx_cnt, rx_cnt;
  logic tx_clr, tx_load, rx_clr, rx_load;
  logic tx_en, rx_en, tx_last, rx_last;
  logic [3:0] cmd;

  scdc_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // Internal byte counters, one per direction
  scdc_ctr #(.W(LEN_W)) u_tx_ctr (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(tx_clr),
    .load(tx_load),
    .load_val(tx_desc_len),
    .dec(tx_byte_rd && tx_st == TX_SEND),
    .cnt(tx_cnt)
  );

  scdc_ctr #(.W(LEN_W)) u_rx_ctr (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(rx_clr),
    .load(rx_load),
    .load_val(max_rx_buffer_length[LEN_W-1:0]),
    .dec(rx_byte_wr && rx_st == RX_FILL),
    .cnt(rx_cnt)
  );

  // Decode: enables, command strobe and end-of-buffer terms
  assign tx_en = channel_mode_register[MODE_TX_EN];
  assign rx_en = channel_mode_register[MODE_RX_EN];
  assign cmd = (wr_en && wr_addr == A_CMD && wr_strb[0]) ? wr_data[3:0] : 4'h0;
  assign tx_last = tx_cnt == '0 || (tx_cnt == LEN_W'(1) && tx_byte_rd);
  assign rx_last = rx_cnt == '0 || (rx_cnt == LEN_W'(1) && rx_byte_wr);

  // Software-visible parameter registers
  always_comb begin
    next_mode = channel_mode_register;
    next_rx_base = rx_descriptor_base;
    next_tx_base = tx_descriptor_base;
    next_fcr = fcr;
    next_max_len = max_rx_buffer_length;
    wr_err = 1'b0;
    if (!wr_en) begin
      wr_err = 1'b0;
    end else if (wr_addr == A_MODE) begin
      next_mode = scdc_merge(channel_mode_register, wr_data, wr_strb);
    end else if (wr_addr == A_RX_BASE) begin
      next_rx_base = scdc_merge(rx_descriptor_base, wr_data, wr_strb);
    end else if (wr_addr == A_TX_BASE) begin
      next_tx_base = scdc_merge(tx_descriptor_base, wr_data, wr_strb);
    end else if (wr_addr == A_FCR) begin
      next_fcr = scdc_merge(fcr, wr_data, wr_strb);
    end else if (wr_addr == A_MAX_RX_LEN) begin
      // Held here; the counter samples it only at a descriptor start
      next_max_len = scdc_merge(max_rx_buffer_length, wr_data, wr_strb);
    end else if (wr_addr == A_CMD || wr_addr == A_RX_PTR || wr_addr == A_TX_PTR) begin
      wr_err = 1'b0;
    end else begin
      wr_err = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_mode_register <= REG_RST;
      rx_descriptor_base <= REG_RST;
      tx_descriptor_base <= REG_RST;
      fcr <= FCR_RST;
      max_rx_buffer_length <= REG_RST;
    end else begin
      channel_mode_register <= next_mode;
      rx_descriptor_base <= next_rx_base;
      tx_descriptor_base <= next_tx_base;
      fcr <= next_fcr;
      max_rx_buffer_length <= next_max_len;
    end
  end

  // Transmitter: descriptor walk, halts and reinitialise
  always_comb begin
    next_tx_st = tx_st;
    next_tx_ptr = tx_descriptor_pointer;
    next_tx_halted = tx_halted;
    next_tx_grace = tx_grace;
    next_tx_wrap = tx_wrap;
    next_tx_fresh = tx_fresh;
    next_tx_done = 1'b0;
    tx_clr = 1'b0;
    tx_load = 1'b0;
    // Pointer follows the base until the ring is first used
    if (tx_fresh) begin
      next_tx_ptr = next_tx_base;
    end
    if (wr_en && wr_addr == A_TX_PTR) begin
      next_tx_ptr = scdc_merge(tx_descriptor_pointer, wr_data, wr_strb);
      next_tx_fresh = 1'b0;
    end
    case (tx_st)
      TX_OFF: begin
        if (tx_en) begin
          next_tx_st = tx_halted ? TX_HALT : TX_IDLE;
        end
      end
      TX_IDLE: begin
        if (cmd == CMD_HALT_TX || cmd == CMD_GRACEFUL_HALT) begin
          next_tx_st = TX_HALT;
          next_tx_halted = 1'b1;
        end else if (tx_desc_ready) begin
          tx_load = 1'b1;
          next_tx_wrap = tx_desc_wrap;
          next_tx_fresh = 1'b0;
          next_tx_st = TX_SEND;
        end
      end
      TX_SEND: begin
        if (cmd == CMD_GRACEFUL_HALT) begin
          next_tx_grace = 1'b1;
        end
        if (cmd == CMD_HALT_TX) begin
          // Stop leaves the pointer on the current descriptor
          next_tx_st = TX_HALT;
          next_tx_halted = 1'b1;
          next_tx_grace = 1'b0;
          tx_clr = 1'b1;
        end else if (tx_last) begin
          next_tx_done = 1'b1;
          next_tx_ptr = scdc_adv(tx_descriptor_pointer, tx_descriptor_base, tx_wrap);
          next_tx_grace = 1'b0;
          next_tx_halted = tx_grace || cmd == CMD_GRACEFUL_HALT;
          next_tx_st = next_tx_halted ? TX_HALT : TX_IDLE;
        end
      end
      TX_HALT: begin
        if (cmd == CMD_RESTART_TX) begin
          next_tx_st = TX_IDLE;
          next_tx_halted = 1'b0;
        end
      end
      default: next_tx_st = TX_OFF;
    endcase
    if (!tx_en) begin
      // Disabled transmitter is held in its reset state
      next_tx_st = TX_OFF;
      next_tx_grace = 1'b0;
      tx_clr = 1'b1;
      tx_load = 1'b0;
      if (cmd == CMD_RESTART_TX) begin
        next_tx_halted = 1'b0;
      end
      if (cmd == CMD_INIT_TX || cmd == CMD_INIT_BOTH) begin
        next_tx_ptr = next_tx_base;
        next_tx_halted = 1'b0;
        next_tx_wrap = 1'b0;
        next_tx_fresh = 1'b1;
      end
    end
    next_tx_rd_ok = next_tx_st == TX_SEND;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st <= TX_OFF;
      tx_descriptor_pointer <= REG_RST;
      tx_halted <= 1'b0;
      tx_grace <= 1'b0;
      tx_wrap <= 1'b0;
      tx_fresh <= 1'b1;
      tx_desc_done <= 1'b0;
      tx_rd_ok <= 1'b0;
    end else begin
      tx_st <= next_tx_st;
      tx_descriptor_pointer <= next_tx_ptr;
      tx_halted <= next_tx_halted;
      tx_grace <= next_tx_grace;
      tx_wrap <= next_tx_wrap;
      tx_fresh <= next_tx_fresh;
      tx_desc_done <= next_tx_done;
      tx_rd_ok <= next_tx_rd_ok;
    end
  end

  // Receiver: fill, close on limit, frame end or command
  always_comb begin
    next_rx_st = rx_st;
    next_rx_ptr = rx_descriptor_pointer;
    next_rx_open = rx_open;
    next_rx_wrap = rx_wrap;
    next_rx_fresh = rx_fresh;
    next_rx_close = 1'b0;
    rx_clr = 1'b0;
    rx_load = 1'b0;
    if (rx_fresh) begin
      next_rx_ptr = next_rx_base;
    end
    if (wr_en && wr_addr == A_RX_PTR) begin
      next_rx_ptr = scdc_merge(rx_descriptor_pointer, wr_data, wr_strb);
      next_rx_fresh = 1'b0;
    end
    case (rx_st)
      RX_OFF: begin
        if (rx_en) begin
          next_rx_st = RX_IDLE;
        end
      end
      RX_IDLE: begin
        if (rx_desc_empty) begin
          // Limit sampled here, never mid-buffer
          rx_load = 1'b1;
          next_rx_wrap = rx_desc_wrap;
          next_rx_open = 1'b1;
          next_rx_fresh = 1'b0;
          next_rx_st = RX_FILL;
        end
      end
      RX_FILL: begin
        if (rx_last || rx_frame_end || cmd == CMD_CLOSE_RX) begin
          next_rx_close = 1'b1;
          next_rx_ptr = scdc_adv(rx_descriptor_pointer, rx_descriptor_base, rx_wrap);
          next_rx_open = 1'b0;
          next_rx_st = RX_IDLE;
        end
      end
      default: next_rx_st = RX_OFF;
    endcase
    if (!rx_en) begin
      // Abort at once; the partly used buffer stays open for close
      next_rx_st = RX_OFF;
      next_rx_close = 1'b0;
      next_rx_ptr = rx_descriptor_pointer;
      next_rx_open = rx_open;
      rx_clr = 1'b1;
      rx_load = 1'b0;
      if (wr_en && wr_addr == A_RX_PTR) begin
        next_rx_ptr = scdc_merge(rx_descriptor_pointer, wr_data, wr_strb);
      end else if (rx_fresh) begin
        next_rx_ptr = next_rx_base;
      end
      if (cmd == CMD_INIT_RX || cmd == CMD_INIT_BOTH) begin
        next_rx_ptr = next_rx_base;
        next_rx_open = 1'b0;
        next_rx_wrap = 1'b0;
        next_rx_fresh = 1'b1;
      end else if (cmd == CMD_CLOSE_RX && rx_open) begin
        next_rx_close = 1'b1;
        next_rx_ptr = scdc_adv(rx_descriptor_pointer, rx_descriptor_base, rx_wrap);
        next_rx_open = 1'b0;
      end
    end
    next_rx_wr_ok = next_rx_st == RX_FILL;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st <= RX_OFF;
      rx_descriptor_pointer <= REG_RST;
      rx_open <= 1'b0;
      rx_wrap <= 1'b0;
      rx_fresh <= 1'b1;
      rx_desc_close <= 1'b0;
      rx_wr_ok <= 1'b0;
    end else begin
      rx_st <= next_rx_st;
      rx_descriptor_pointer <= next_rx_ptr;
      rx_open <= next_rx_open;
      rx_wrap <= next_rx_wrap;
      rx_fresh <= next_rx_fresh;
      rx_desc_close <= next_rx_close;
      rx_wr_ok <= next_rx_wr_ok;
    end
  end

  // Function code bytes go straight from their register
  assign rx_function_code = fcr[7:0];
  assign tx_function_code = fcr[15:8];

  // Read mux; unmapped addresses answer with an error
  always_comb begin
    rd_data = 32'h0;
    rd_err = 1'b0;
    if (rd_addr == A_MODE) begin
      rd_data = {16'h0, channel_mode_register};
    end else if (rd_addr == A_CMD) begin
      rd_data = 32'h0;
    end else if (rd_addr == A_RX_BASE) begin
      rd_data = {16'h0, rx_descriptor_base};
    end else if (rd_addr == A_TX_BASE) begin
      rd_data = {16'h0, tx_descriptor_base};
    end else if (rd_addr == A_FCR) begin
      rd_data = {16'h0, fcr};
    end else if (rd_addr == A_MAX_RX_LEN) begin
      rd_data = {16'h0, max_rx_buffer_length};
    end else if (rd_addr == A_RX_PTR) begin
      rd_data = {16'h0, rx_descriptor_pointer};
    end else if (rd_addr == A_TX_PTR) begin
      rd_data = {16'h0, tx_descriptor_pointer};
    end else if (rd_addr == A_RX_CNT) begin
      rd_data = 32'(rx_cnt);
    end else if (rd_addr == A_TX_CNT) begin
      rd_data = 32'(tx_cnt);
    end else if (rd_addr == A_STATUS) begin
      rd_data = {26'h0, rx_open, tx_halted, rx_st, tx_st};
    end else begin
      rd_err = 1'b1;
    end
  end
endmodule // scdc_top

// ==== scdc_assertions.sv ====
`timescale 1ns/100ps
module scdc_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Read handshake
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Descriptor side
  input wire logic tx_desc_ready,
  input wire logic tx_rd_ok,
  input wire logic tx_desc_done,
  input wire logic [15:0] tx_descriptor_pointer,
  input wire logic rx_desc_empty,
  input wire logic rx_frame_end,
  input wire logic rx_wr_ok,
  input wire logic rx_desc_close,
  input wire logic [15:0] rx_descriptor_pointer
);
  // One domain; sync reset masks the checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Closing pulses drop the open level and last one cycle
  sequence tx_end;
    !tx_rd_ok ##1 !tx_desc_done;
  endsequence
  sequence rx_end;
    !rx_wr_ok ##1 !rx_desc_close;
  endsequence
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  tx_start_a: assert property ($rose(tx_rd_ok) |-> $past(tx_desc_ready))
    else $error("tx start without ready");
  tx_done_a: assert property (tx_desc_done |-> $past(tx_rd_ok) ##0 tx_end)
    else $error("tx done out of place");
  tx_ptr_hold_a: assert property (tx_rd_ok |-> $stable(tx_descriptor_pointer))
    else $error("tx pointer moved in buffer");
  rx_ptr_hold_a: assert property (rx_wr_ok |-> $stable(rx_descriptor_pointer))
    else $error("rx pointer moved in buffer");
  rx_start_a: assert property ($rose(rx_wr_ok) |-> $past(rx_desc_empty))
    else $error("rx open without empty");
  rx_early_a: assert property (rx_wr_ok && rx_frame_end |=> rx_desc_close)
    else $error("frame end did not close");
  rx_close_a: assert property (rx_desc_close |-> rx_end)
    else $error("rx close out of place");
endmodule // scdc_chk
bind scdc_top scdc_chk i_chk (.*);

// ==== scdc_far.sv ====
`timescale 1ns/100ps
module scdc_far (
  // Clock and bench control
  input wire logic aclk,
  input wire logic [7:0] rx_stop,
  // Channel side
  input wire logic tx_rd_ok,
  input wire logic rx_wr_ok,
  input wire logic rx_desc_close,
  output logic tx_byte_rd,
  output logic rx_byte_wr,
  output logic rx_frame_end,
  output logic [7:0] rx_n
);
  logic ph = 1'h0;
  initial {tx_byte_rd, rx_byte_wr, rx_frame_end, rx_n} = 11'h0;
  // Byte every other cycle, so a frame end never meets a byte
  always @(posedge aclk) begin
    ph <= ~ph;
    tx_byte_rd <= tx_rd_ok && ph;
    rx_byte_wr <= rx_wr_ok && ph;
    rx_frame_end <= rx_wr_ok && rx_byte_wr && rx_stop != 8'h0 && rx_n == rx_stop - 8'h1;
    if (rx_desc_close) rx_n <= 8'h0;
    else if (rx_byte_wr && rx_wr_ok) rx_n <= rx_n + 8'h1;
  end
endmodule // scdc_far

// ==== tb.sv ====
`timescale 1ns/100ps
module tb import scdc_pkg::*; ;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [5:0] s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, lf = 32'ha314;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic tx_desc_ready = 1'h0, tx_desc_wrap = 1'h0, rx_desc_empty = 1'h0, rx_desc_wrap = 1'h0;
  logic [15:0] tx_desc_len = 16'h0, tx_descriptor_pointer, rx_descriptor_pointer, tp = 16'h80, rp = 16'h40;
  logic tx_byte_rd, rx_byte_wr, rx_frame_end, tx_rd_ok, tx_desc_done, rx_wr_ok, rx_desc_close;
  logic [7:0] tx_function_code, rx_function_code, rx_stop = 8'h0, rx_n;
  logic [33:0] rq[$], bq[$], pq[$], xq[$], nq[$];
  int error_cnt = 0, n_tests = 0;
  scdc_top i_dut (.*);
  scdc_far i_far (.*);
  always #2 aclk = ~aclk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic [1:0] r = RESP_OK);
    bq.push_back({r, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] d, input logic [1:0] r = RESP_OK);
    rq.push_back({r, 16'h0, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask
  // Ready dropped once taken, so only n descriptors go out
  task automatic tx_run(input int n);
    repeat (n) begin
      tp = (tp == 16'h88) ? 16'h80 : tp + 16'h8;
      pq.push_back({18'h0, tp});
      lf = lfsr(lf);
      @(posedge aclk);
      tx_desc_len <= {13'h0, lf[2:0]};
      tx_desc_ready <= 1'h1;
      do @(posedge aclk); while (!tx_rd_ok);
      tx_desc_ready <= 1'h0;
      do @(posedge aclk); while (tx_rd_ok);
    end
  endtask
  task automatic rx_buf(input logic [7:0] s, input logic [7:0] e);
    rp = (rp == 16'h48) ? 16'h40 : rp + 16'h8;
    xq.push_back({18'h0, rp});
    nq.push_back({26'h0, e});
    @(posedge aclk);
    rx_stop <= s;
    rx_desc_empty <= 1'h1;
    do @(posedge aclk); while (!rx_wr_ok);
    rx_desc_empty <= 1'h0;
  endtask
  // Two-entry rings: second descriptor carries the wrap bit
  always @(posedge aclk) begin
    tx_desc_wrap <= tx_descriptor_pointer == 16'h88;
    rx_desc_wrap <= rx_descriptor_pointer == 16'h48;
  end
  // Oldest note against each answer; 8'hff skips the byte count
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (tx_desc_done) chk({18'h0, tx_descriptor_pointer}, pq.pop_front());
    if (rx_desc_close) chk({18'h0, rx_descriptor_pointer}, xq.pop_front());
    if (rx_desc_close && nq[0] != 34'hff) chk({26'h0, rx_n}, nq[0]);
    if (rx_desc_close) void'(nq.pop_front());
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(A_FCR, FCR_RST);
    rd(A_RX_PTR, REG_RST);
    rd(6'h2c, 16'h0, RESP_SLVERR);
    wr(6'h30, 16'h1, RESP_SLVERR);
    wr(A_RX_CNT, 16'h1, RESP_SLVERR);
    wr(A_FCR, 16'h8888);
    rd(A_FCR, 16'h8888);
    chk({18'h0, tx_function_code, rx_function_code}, 34'h8888);
    wr(A_RX_BASE, 16'h40);
    wr(A_TX_BASE, 16'h80);
    wr(A_MAX_RX_LEN, 16'h3);
    wr(A_MODE, 16'h3);
    rx_buf(8'h0, 8'h3);
    wr(A_MAX_RX_LEN, 16'h7);
    do @(posedge aclk); while (rx_wr_ok);
    rx_buf(8'h4, 8'h4);
    do @(posedge aclk); while (rx_wr_ok);
    rx_buf(8'h0, 8'hff);
    wr(A_MODE, 16'h1);
    @(posedge aclk);
    chk({33'h0, rx_wr_ok}, 34'h0);
    wr(A_CMD, {12'h0, CMD_CLOSE_RX});
    wr(A_CMD, {12'h0, CMD_INIT_RX});
    rd(A_RX_PTR, 16'h40);
    tx_run(3);
    wr(A_MODE, 16'h0);
    tx_desc_ready <= 1'h1;
    repeat (8) @(posedge aclk);
    chk({33'h0, tx_rd_ok}, 34'h0);
    tx_desc_ready <= 1'h0;
    wr(A_CMD, {12'h0, CMD_INIT_TX});
    rd(A_TX_PTR, 16'h80);
    tp = 16'h80;
    wr(A_MODE, 16'h1);
    tx_run(1);
    wr(A_CMD, {12'h0, CMD_HALT_TX});
    rd(A_STATUS, 16'h13);
    wr(A_MODE, 16'h0);
    for (int c = 1; c < 8; c++) wr(A_CMD, c[15:0]);
    rd(A_TX_PTR, 16'h80);
    rd(A_STATUS, 16'h0);
    // Pointers rewritten only with both directions disabled
    wr(A_RX_PTR, 16'h48);
    wr(A_TX_PTR, 16'h88);
    rd(A_RX_PTR, 16'h48);
    rd(A_TX_PTR, 16'h88);
    // Let the watcher take the last answer; a close with no open buffer must not pulse
    @(posedge aclk);
    chk(34'(rq.size() + bq.size() + pq.size() + xq.size() + nq.size()), 34'h0);
    tally_and_finish();
  end
  // Run needs a few hundred cycles; this cuts off a hang at 10000 cycles
  initial begin
    #40000;
    error_cnt++;
    tally_and_finish();
  end
endmodule // tb
